// file: design/dps_pkg.sv
// Constants for the dual-phase switching sequencer: register map,
// field positions, reset values, pin bit order and timing counts.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
//
// Overview of operation
// - Switching clock toggles on every oscillator tick, so it runs at half.
// - Channel one turns on at each switching-clock rise.
// - Channel two turns on at each switching-clock fall.
// - On-time ends when the ramp reaches the commanded duty.
// - Current limit ends on-time at once; restart at next start edge.
// - Short-circuit sense lets only every fourth start through.
// - Each sync rise forces an oscillator tick and restarts its count.
// - Phase clock output follows switching clock delayed by 1/8 period.
// - Supply lockout forces both switches off.
// - Lockout clear and enable high ramp the reference in 64 steps.
// - Whole ramp takes 2048 oscillator ticks.
// - Each channel has its own active-high enable.
// - Enable low stops the channel and pulls power-ok low.
// - Output-low comparator pulls power-ok low.
// - Over-temperature stops both, drops power-ok, resets soft-start.
// - Without sync edges the internal count keeps ticking.
// - On-time never exceeds the maximum duty.

package dps_pkg;

   // Register byte addresses
   localparam logic [3:0]  OSC_PERIOD_ADDR = 4'h0;
   localparam logic [3:0]  DUTY_CMD_ADDR   = 4'h4;
   localparam logic [3:0]  STATUS_ADDR     = 4'h8;
   localparam logic [3:0]  SOFT_REF_ADDR   = 4'hc;

   // Reset values and limits
   localparam logic [15:0] OSC_PERIOD_RST  = 16'h0014;
   localparam logic [15:0] OSC_PERIOD_MIN  = 16'h0004;
   localparam logic [15:0] DUTY_CMD_RST    = 16'h0000;
   localparam logic [7:0]  MAX_DUTY        = 8'he1;
   localparam logic [6:0]  SS_FULL         = 7'h40;
   localparam logic [4:0]  SS_DIV_LAST     = 5'h1f;

   // Pin vector bit order
   localparam int PIN_SYNC  = 0;
   localparam int PIN_EN1   = 1;
   localparam int PIN_EN2   = 2;
   localparam int PIN_SUPPLY_LOW_LOCKOUT  = 3;
   localparam int PIN_OT    = 4;
   localparam int PIN_IL1   = 5;
   localparam int PIN_IL2   = 6;
   localparam int PIN_SC1   = 7;
   localparam int PIN_SC2   = 8;
   localparam int PIN_LOW1  = 9;
   localparam int PIN_LOW2  = 10;
   localparam int PIN_W     = 11;

   // Status register bit positions
   localparam int ST_SWCLK  = 0;
   localparam int ST_SYNC   = 1;
   localparam int ST_DONE1  = 2;
   localparam int ST_DONE2  = 3;
   localparam int ST_FOLD1  = 4;
   localparam int ST_FOLD2  = 5;
   localparam int ST_OK1    = 6;
   localparam int ST_OK2    = 7;
   localparam int ST_SUPPLY_LOW_LOCKOUT   = 8;
   localparam int ST_OT     = 9;

endpackage

// file: design/dps_sequencer.sv
// Dual-phase switching sequencer: oscillator, interleaved PWM,
// phase clock output, soft-start, protection and power-ok.
// Assumes pins arrive asynchronously and registers sit on Avalon-MM.
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.

`timescale 1ns/1ps
`default_nettype none

module dps_sequencer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   // Sync and enables
   input  wire logic        syncIn,
   input  wire logic        chanOneEnable,
   input  wire logic        chanTwoEnable,
   // Supply and temperature sense
   input  wire logic        supplyLowLockout,
   input  wire logic        overTemp,
   // Power stage comparators
   input  wire logic        curLimitOne,
   input  wire logic        curLimitTwo,
   input  wire logic        feedbackShortOne,
   input  wire logic        feedbackShortTwo,
   input  wire logic        outputLowOne,
   input  wire logic        outputLowTwo,
   // Switch drives and phase clock
   output var  logic        switchOne,
   output var  logic        switchTwo,
   output var  logic        phaseClockOut,
   // Open-drain power-ok pins
   output var  logic        chanOnePowerOkOut,
   output var  logic        chanOnePowerOkOe,
   output var  logic        chanTwoPowerOkOut,
   output var  logic        chanTwoPowerOkOe
);

   // Ramp has reached the commanded fraction of the period
   function automatic logic dutyReached(input logic [15:0] ramp,
                                        input logic [7:0]  duty,
                                        input logic [15:0] half);
      logic [31:0] lhs;
      logic [31:0] rhs;
      // Stop once the next cycle would pass the target, so on-time rounds down
      lhs = {8'h00, ramp, 8'h00} + 32'h0000_0200;
      rhs = 32'(duty) * 32'({half, 1'b0});
      return lhs > rhs;
   endfunction

   // Duty after max-duty clamp and soft-start ceiling
   function automatic logic [7:0] dutyLimit(input logic [7:0] duty,
                                            input logic [6:0] ref7);
      logic [8:0] ceil;
      logic [7:0] d;
      ceil = {ref7, 2'b00};
      d    = (duty > dps_pkg::MAX_DUTY) ? dps_pkg::MAX_DUTY : duty;
      return ({1'b0, d} < ceil) ? d : ceil[7:0];
   endfunction

   logic [dps_pkg::PIN_W-1:0] pinRaw;
   logic [dps_pkg::PIN_W-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   logic        syncPrev_q;
   logic [15:0] oscPeriod_q, oscPeriod_d;
   logic [15:0] dutyCmd_q, dutyCmd_d;
   logic [15:0] tickCnt_q, tickCnt_d;
   logic [15:0] tickLen_q, tickLen_d;
   logic        swClk_q, swClk_d;
   logic        syncActive_q, syncActive_d;
   logic [15:0] phaseDly_q, phaseDly_d;
   logic        phasePend_q, phasePend_d;
   logic        phaseOut_q, phaseOut_d;
   logic        on_q [2];
   logic        on_d [2];
   logic [15:0] ramp_q [2];
   logic [15:0] ramp_d [2];
   logic [1:0]  fold_q [2];
   logic [1:0]  fold_d [2];
   logic [4:0]  ssDiv_q [2];
   logic [4:0]  ssDiv_d [2];
   logic [6:0]  ssRef_q [2];
   logic [6:0]  ssRef_d [2];
   logic        okOe_q [2];
   logic        okOe_d [2];
   logic        waitreq_q, waitreq_d;
   logic [31:0] rdata_q, rdata_d;
   logic        syncRise, intTick, tick, accept;
   logic [15:0] period;
   logic        start [2];
   logic        run [2];
   logic [7:0]  effDuty [2];
   logic [31:0] statusWord;

   // Pins gathered for the common synchroniser
   assign pinRaw = {outputLowTwo, outputLowOne, feedbackShortTwo,
                    feedbackShortOne, curLimitTwo, curLimitOne, overTemp,
                    supplyLowLockout, chanTwoEnable, chanOneEnable, syncIn};

   // Pin filter: a change counts once stages two and three agree
   always_comb begin
      for (int i = 0; i < dps_pkg::PIN_W; i++) begin
         pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
      end
   end

   // Oscillator, switching clock and phase clock
   always_comb begin
      period   = (oscPeriod_q < dps_pkg::OSC_PERIOD_MIN) ? dps_pkg::OSC_PERIOD_MIN
                                                          : oscPeriod_q;
      syncRise = pin_q[dps_pkg::PIN_SYNC] & ~syncPrev_q;
      intTick  = tickCnt_q >= (period - 16'h0001);
      tick     = syncRise | intTick;
      tickCnt_d    = tick ? 16'h0000 : tickCnt_q + 16'h0001;
      tickLen_d    = tick ? tickCnt_q + 16'h0001 : tickLen_q;
      swClk_d      = tick ? ~swClk_q : swClk_q;
      syncActive_d = syncActive_q;
      if (syncRise) begin
         syncActive_d = 1'b1;
      end else if (intTick) begin
         syncActive_d = 1'b0;                        // Sync lost, internal timing rules
      end
      // Delay of a quarter of the last tick interval is 45 degrees
      phaseDly_d  = phaseDly_q;
      phasePend_d = phasePend_q;
      phaseOut_d  = phaseOut_q;
      if (tick) begin
         phaseDly_d  = {2'b00, tickLen_q[15:2]};
         phasePend_d = 1'b1;
      end else if (phasePend_q) begin
         if (phaseDly_q == 16'h0000) begin
            phaseOut_d  = swClk_q;
            phasePend_d = 1'b0;
         end else begin
            phaseDly_d = phaseDly_q - 16'h0001;
         end
      end
   end

   // Per-channel PWM, foldback, soft-start and power-ok
   always_comb begin
      start[0] = tick & ~swClk_q;
      start[1] = tick & swClk_q;
      run[0]   = pin_q[dps_pkg::PIN_EN1] & ~pin_q[dps_pkg::PIN_SUPPLY_LOW_LOCKOUT]
                 & ~pin_q[dps_pkg::PIN_OT];
      run[1]   = pin_q[dps_pkg::PIN_EN2] & ~pin_q[dps_pkg::PIN_SUPPLY_LOW_LOCKOUT]
                 & ~pin_q[dps_pkg::PIN_OT];
      for (int c = 0; c < 2; c++) begin
         logic il;
         logic sc;
         logic low;
         il  = pin_q[dps_pkg::PIN_IL1 + c];
         sc  = pin_q[dps_pkg::PIN_SC1 + c];
         low = pin_q[dps_pkg::PIN_LOW1 + c];
         effDuty[c] = dutyLimit(dutyCmd_q[c*8 +: 8], ssRef_q[c]);
         // Foldback counter only passes every fourth start
         fold_d[c] = ~sc ? 2'b00 : (start[c] ? fold_q[c] + 2'b01 : fold_q[c]);
         ramp_d[c] = start[c] ? 16'h0000 : (on_q[c] ? ramp_q[c] + 16'h0001 : ramp_q[c]);
         on_d[c]   = on_q[c];
         if (!run[c]) begin
            on_d[c] = 1'b0;
         end else if (start[c]) begin
            on_d[c] = (effDuty[c] != 8'h00) & (~sc | (fold_q[c] == 2'b00));
         end else if (on_q[c] && il) begin
            on_d[c] = 1'b0;
         end else if (on_q[c] && dutyReached(ramp_q[c], effDuty[c], tickLen_q)) begin
            on_d[c] = 1'b0;
         end
         // Soft-start: one step per 32 ticks, 64 steps, 2048 ticks total
         ssDiv_d[c] = ssDiv_q[c];
         ssRef_d[c] = ssRef_q[c];
         if (!run[c]) begin
            ssDiv_d[c] = 5'h00;
            ssRef_d[c] = 7'h00;
         end else if (tick && ssRef_q[c] != dps_pkg::SS_FULL) begin
            ssDiv_d[c] = ssDiv_q[c] + 5'h01;
            if (ssDiv_q[c] == dps_pkg::SS_DIV_LAST) begin
               ssRef_d[c] = ssRef_q[c] + 7'h01;
            end
         end
         // Pull low unless running, ramped up and in regulation
         okOe_d[c] = ~(run[c] & (ssRef_q[c] == dps_pkg::SS_FULL) & ~low);
      end
   end

   // Status word for register reads
   always_comb begin
      statusWord                   = 32'h0000_0000;
      statusWord[dps_pkg::ST_SWCLK] = swClk_q;
      statusWord[dps_pkg::ST_SYNC]  = syncActive_q;
      statusWord[dps_pkg::ST_DONE1] = ssRef_q[0] == dps_pkg::SS_FULL;
      statusWord[dps_pkg::ST_DONE2] = ssRef_q[1] == dps_pkg::SS_FULL;
      statusWord[dps_pkg::ST_FOLD1] = pin_q[dps_pkg::PIN_SC1];
      statusWord[dps_pkg::ST_FOLD2] = pin_q[dps_pkg::PIN_SC2];
      statusWord[dps_pkg::ST_OK1]   = ~okOe_q[0];
      statusWord[dps_pkg::ST_OK2]   = ~okOe_q[1];
      statusWord[dps_pkg::ST_SUPPLY_LOW_LOCKOUT]  = pin_q[dps_pkg::PIN_SUPPLY_LOW_LOCKOUT];
      statusWord[dps_pkg::ST_OT]    = pin_q[dps_pkg::PIN_OT];
   end

   // Bus slave: one wait cycle, then a single-cycle acceptance
   always_comb begin
      waitreq_d   = ~((read | write) & waitreq_q);
      accept      = (read | write) & ~waitreq_q;
      oscPeriod_d = oscPeriod_q;
      dutyCmd_d   = dutyCmd_q;
      if (accept && write) begin
         case (address)
            dps_pkg::OSC_PERIOD_ADDR: oscPeriod_d = writedata[15:0];
            dps_pkg::DUTY_CMD_ADDR:   dutyCmd_d   = writedata[15:0];
            default: ;                               // Read-only or unmapped
         endcase
      end
      rdata_d = 32'h0000_0000;
      if (read && waitreq_q) begin
         case (address)
            dps_pkg::OSC_PERIOD_ADDR: rdata_d = {16'h0000, oscPeriod_q};
            dps_pkg::DUTY_CMD_ADDR:   rdata_d = {16'h0000, dutyCmd_q};
            dps_pkg::STATUS_ADDR:     rdata_d = statusWord;
            dps_pkg::SOFT_REF_ADDR:   rdata_d = {17'h00000, ssRef_q[1], 1'b0, ssRef_q[0]};
            default:                  rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Synchroniser stages; stage one feeds stage two only
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         pin_q <= '0;
      end else begin
         s1_q  <= pinRaw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   // Timing and bus registers
   always_ff @(posedge clk) begin
      if (reset) begin
         syncPrev_q   <= 1'b0;
         oscPeriod_q  <= dps_pkg::OSC_PERIOD_RST;
         dutyCmd_q    <= dps_pkg::DUTY_CMD_RST;
         tickCnt_q    <= 16'h0000;
         tickLen_q    <= dps_pkg::OSC_PERIOD_RST;
         swClk_q      <= 1'b0;
         syncActive_q <= 1'b0;
         phaseDly_q   <= 16'h0000;
         phasePend_q  <= 1'b0;
         phaseOut_q   <= 1'b0;
         waitreq_q    <= 1'b1;
         rdata_q      <= 32'h0000_0000;
      end else begin
         syncPrev_q   <= pin_q[dps_pkg::PIN_SYNC];
         oscPeriod_q  <= oscPeriod_d;
         dutyCmd_q    <= dutyCmd_d;
         tickCnt_q    <= tickCnt_d;
         tickLen_q    <= tickLen_d;
         swClk_q      <= swClk_d;
         syncActive_q <= syncActive_d;
         phaseDly_q   <= phaseDly_d;
         phasePend_q  <= phasePend_d;
         phaseOut_q   <= phaseOut_d;
         waitreq_q    <= waitreq_d;
         rdata_q      <= rdata_d;
      end
   end

   // Channel registers
   always_ff @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         if (reset) begin
            on_q[c]    <= 1'b0;
            ramp_q[c]  <= 16'h0000;
            fold_q[c]  <= 2'b00;
            ssDiv_q[c] <= 5'h00;
            ssRef_q[c] <= 7'h00;
            okOe_q[c]  <= 1'b1;
         end else begin
            on_q[c]    <= on_d[c];
            ramp_q[c]  <= ramp_d[c];
            fold_q[c]  <= fold_d[c];
            ssDiv_q[c] <= ssDiv_d[c];
            ssRef_q[c] <= ssRef_d[c];
            okOe_q[c]  <= okOe_d[c];
         end
      end
   end

   // Outputs straight from flip-flops; open-drain data is always low
   always_comb begin
      readdata          = rdata_q;
      waitrequest       = waitreq_q;
      switchOne         = on_q[0];
      switchTwo         = on_q[1];
      phaseClockOut     = phaseOut_q;
      chanOnePowerOkOut = 1'b0;
      chanOnePowerOkOe  = okOe_q[0];
      chanTwoPowerOkOut = 1'b0;
      chanTwoPowerOkOe  = okOe_q[1];
   end

endmodule // dps_sequencer

`default_nettype wire

// file: verification/dps_power_stage.sv
// Power stage and sync source model: sync clock and channel one current sense.
// Assumes the bench sets the sync half period and the limit delay.
`timescale 1ns/1ps
`default_nettype none
module dps_power_stage (
   // Clock and bench controls
   input  wire logic       clk,
   input  wire logic       syncOn,
   input  wire logic [7:0] syncHalf,
   input  wire logic [7:0] limitAfter,
   // Stage
   input  wire logic       switchOne,
   output var  logic       syncIn,
   output var  logic       curLimitOne
);
   logic [7:0] syncCnt = 8'h0;
   logic [7:0] onCnt = 8'h0;
   initial syncIn = 1'h0;
   initial curLimitOne = 1'h0;
   // Sync stands for a master's phase clock output: equal halves of at least two clocks, low when stopped
   always @(posedge clk) begin
      syncCnt <= (!syncOn || syncCnt + 8'h1 >= syncHalf) ? 8'h0 : syncCnt + 8'h1;
      syncIn <= syncOn && (syncCnt + 8'h1 >= syncHalf) ? !syncIn : syncIn && syncOn;
   end
   // Current ramps while on; sense trips after the set delay
   always @(posedge clk) begin
      onCnt <= switchOne ? onCnt + 8'h1 : 8'h0;
      curLimitOne <= (limitAfter != 8'h0) && switchOne && (onCnt >= limitAfter);
   end
endmodule // dps_power_stage
`default_nettype wire

// file: verification/dps_sequencer_assertions.sv
// Checker for the sequencer's bus answer and protection outputs.
// Assumes binding to every sequencer instance, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dps_seq_checker (
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Pins
   input wire logic        chanOneEnable,
   input wire logic        chanTwoEnable,
   input wire logic        supplyLowLockout,
   input wire logic        overTemp,
   input wire logic        curLimitOne,
   input wire logic        switchOne,
   input wire logic        switchTwo,
   input wire logic        phaseClockOut,
   input wire logic        chanOnePowerOkOut,
   input wire logic        chanOnePowerOkOe,
   input wire logic        chanTwoPowerOkOut,
   input wire logic        chanTwoPowerOkOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // A request is answered one cycle after it rises, and only for one cycle
   sequence req_start;
      $rose(read || write);
   endsequence
   sequence one_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   bus_answer_a: assert property (req_start |=> one_answer)
      else $error("bus answer not a single cycle");
   idle_data_a: assert property (waitrequest |-> readdata == 32'h0)
      else $error("read data not zero while waiting");
   reset_state_a: assert property (disable iff (1'h0) reset |=> waitrequest && !switchOne && !switchTwo
      && !phaseClockOut && chanOnePowerOkOe && chanTwoPowerOkOe) else $error("reset state wrong");
   // Eight cycles cover the pin synchronisers and the output register
   lockout_off_a: assert property (supplyLowLockout[*8] |-> !switchOne && !switchTwo)
      else $error("switch on during lockout");
   hot_off_a: assert property (overTemp[*8] |-> !switchOne && !switchTwo && chanOnePowerOkOe
      && chanTwoPowerOkOe) else $error("switch on or power ok during overtemp");
   one_off_a: assert property (!chanOneEnable[*8] |-> !switchOne && chanOnePowerOkOe)
      else $error("channel one active while disabled");
   two_off_a: assert property (!chanTwoEnable[*8] |-> !switchTwo && chanTwoPowerOkOe)
      else $error("channel two active while disabled");
   limit_end_a: assert property ($rose(curLimitOne) |-> ##[1:8] !switchOne)
      else $error("current limit did not end pulse");
   open_drain_a: assert property (!chanOnePowerOkOut && !chanTwoPowerOkOut)
      else $error("power ok data not low");
endmodule // dps_seq_checker
bind dps_sequencer dps_seq_checker dps_seq_checker_i (.clk, .reset, .read, .write, .readdata, .waitrequest,
   .chanOneEnable, .chanTwoEnable, .supplyLowLockout, .overTemp, .curLimitOne, .switchOne, .switchTwo,
   .phaseClockOut, .chanOnePowerOkOut, .chanOnePowerOkOe, .chanTwoPowerOkOut, .chanTwoPowerOkOe);
`default_nettype wire

// file: verification/tb_dps_sequencer.sv
// Self-checking bench: registers, soft-start, timing, protection.
// Assumes the checker is bound and the stage model drives sync and limit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("BAD %s expected %h seen %h", n, e, g); end end
module tb_dps_sequencer;
   typedef struct { string n; logic [31:0] v; } dps_note_type;
   localparam int TICK = 20;
   logic clk = 1'h0, reset = 1'h1, read = 1'h0, write = 1'h0, syncOn = 1'h0, syncIn, curLimitOne;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata;
   logic [7:0] syncHalf = 8'h4, limitAfter = 8'h0, duty2;
   logic chanOneEnable = 1'h0, chanTwoEnable = 1'h0, supplyLowLockout = 1'h0, overTemp = 1'h0;
   logic curLimitTwo = 1'h0, feedbackShortOne = 1'h0, feedbackShortTwo = 1'h0, outputLowOne = 1'h0;
   logic outputLowTwo = 1'h0, waitrequest, switchOne, switchTwo, phaseClockOut;
   logic chanOnePowerOkOut, chanOnePowerOkOe, chanTwoPowerOkOut, chanTwoPowerOkOe;
   wire [2:0] mon = {phaseClockOut, switchTwo, switchOne};
   int num_errors = 0, checks_done = 0, n;
   dps_note_type expQ[$];
   logic [31:0] gotQ[$];
   event seenEv;
   dps_sequencer dps_sequencer_i (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .syncIn, .chanOneEnable, .chanTwoEnable, .supplyLowLockout, .overTemp, .curLimitOne, .curLimitTwo,
      .feedbackShortOne, .feedbackShortTwo, .outputLowOne, .outputLowTwo, .switchOne, .switchTwo,
      .phaseClockOut, .chanOnePowerOkOut, .chanOnePowerOkOe, .chanTwoPowerOkOut, .chanTwoPowerOkOe);
   dps_power_stage dps_power_stage_i (.clk, .syncOn, .syncHalf, .limitAfter, .switchOne, .syncIn, .curLimitOne);
   always #25 clk = ~clk;
   // Oldest note is matched against each result as it shows up
   task automatic cmp(input logic [31:0] g);
      dps_note_type e;
      e = expQ.pop_front();
      `CHK(e.n, e.v, g)
   endtask
   always @(posedge clk) if (read && waitrequest === 1'h0) cmp(readdata);
   always @(seenEv) while (gotQ.size() > 0) cmp(gotQ.pop_front());
   // Request held until waitrequest is seen low, then one idle edge
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'h0);
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
      expQ.push_back('{nm, e});
      bus(a, 1'h0, 32'h0);
   endtask
   task automatic post(input string nm, input logic [31:0] e, input logic [31:0] g);
      expQ.push_back('{nm, e});
      gotQ.push_back(g);
      ->seenEv;
   endtask
   // Cycles from a rise of mon[a] to the next rise of mon[b], or its high time
   task automatic gap(input int a, input int b, input bit h, output int c);
      logic p;
      c = 0;
      @(posedge clk iff !mon[a]);
      @(posedge clk iff mon[a]);
      do begin
         p = mon[b];
         @(posedge clk);
         c++;
      end while ((h ? mon[a] : !(mon[b] && !p)) && c < 4000);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #(40000 * 50);
      num_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(32'hf0688403));
      duty2 = 8'($urandom_range(8'hc0, 8'h20));
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      // Defaults, an unmapped place and a read-only place
      rd("period", dps_pkg::OSC_PERIOD_ADDR, 32'(dps_pkg::OSC_PERIOD_RST));
      rd("duty", dps_pkg::DUTY_CMD_ADDR, 32'(dps_pkg::DUTY_CMD_RST));
      rd("hole", 4'h2, 32'h0);
      bus(dps_pkg::SOFT_REF_ADDR, 1'h1, 32'hffff);
      rd("ref", dps_pkg::SOFT_REF_ADDR, 32'h0);
      bus(dps_pkg::OSC_PERIOD_ADDR, 1'h1, 32'h4);
      bus(dps_pkg::DUTY_CMD_ADDR, 1'h1, {16'h0, duty2, 8'h80});
      rd("duty", dps_pkg::DUTY_CMD_ADDR, {16'h0, duty2, 8'h80});
      $display("registers done");
      // Ramp at four clocks a tick: 2000 ticks give step 62, 2100 the top
      chanOneEnable <= 1'h1;
      chanTwoEnable <= 1'h1;
      repeat (8000) @(posedge clk);
      rd("ref mid", dps_pkg::SOFT_REF_ADDR, 32'h3e3e);
      repeat (400) @(posedge clk);
      rd("ref full", dps_pkg::SOFT_REF_ADDR, 32'h4040);
      post("pok", 32'h0, {chanTwoPowerOkOe, chanOnePowerOkOe});
      outputLowOne <= 1'h1;
      repeat (10) @(posedge clk);
      post("pok low", 32'h1, {chanTwoPowerOkOe, chanOnePowerOkOe});
      outputLowOne <= 1'h0;
      $display("soft-start done");
      bus(dps_pkg::OSC_PERIOD_ADDR, 1'h1, 32'(TICK));
      repeat (100) @(posedge clk);
      gap(0, 0, 1'h0, n);
      post("period", 2 * TICK, n);
      // Just after a channel one start: switching clock high, both ramps done, both ok
      rd("status", dps_pkg::STATUS_ADDR, 32'h00cd);
      gap(0, 1, 1'h0, n);
      post("ch2 offset", TICK, n);
      gap(0, 2, 1'h0, n);
      post("phase", 1, n > 0 && n < TICK);
      gap(0, 0, 1'h1, n);
      post("on half", 1, n >= TICK - 2 && n <= TICK + 2);
      bus(dps_pkg::DUTY_CMD_ADDR, 1'h1, {16'h0, duty2, 8'hff});
      repeat (100) @(posedge clk);
      gap(0, 0, 1'h1, n);
      // Maximum duty of 0.88 leaves at most 35 of 40 cycles on
      post("on max", 1, n > 31 && n <= 35);
      bus(dps_pkg::DUTY_CMD_ADDR, 1'h1, {16'h0, duty2, 8'h80});
      feedbackShortOne <= 1'h1;
      repeat (200) @(posedge clk);
      gap(0, 0, 1'h0, n);
      post("foldback", 8 * TICK, n);
      feedbackShortOne <= 1'h0;
      limitAfter <= 8'h2;
      repeat (200) @(posedge clk);
      gap(0, 0, 1'h1, n);
      post("limit on", 1, n < TICK / 2 + 2);
      gap(0, 0, 1'h0, n);
      post("limit next", 2 * TICK, n);
      limitAfter <= 8'h0;
      syncHalf <= 8'($urandom_range(8, 4));
      syncOn <= 1'h1;
      repeat (200) @(posedge clk);
      gap(0, 0, 1'h0, n);
      post("sync period", 4 * syncHalf, n);
      syncOn <= 1'h0;
      repeat (200) @(posedge clk);
      gap(0, 0, 1'h0, n);
      post("sync lost", 2 * TICK, n);
      $display("timing done");
      // Independent stop, lockout, then overtemp in mid-ramp
      chanTwoEnable <= 1'h0;
      repeat (20) @(posedge clk);
      rd("ref en2", dps_pkg::SOFT_REF_ADDR, 32'h0040);
      post("pok en2", 32'h2, {chanTwoPowerOkOe, chanOnePowerOkOe});
      supplyLowLockout <= 1'h1;
      repeat (20) @(posedge clk);
      rd("ref lockout", dps_pkg::SOFT_REF_ADDR, 32'h0);
      supplyLowLockout <= 1'h0;
      chanTwoEnable <= 1'h1;
      // About 80 ticks: both references two steps up before the shutdown
      repeat (1600) @(posedge clk);
      rd("ref pre", dps_pkg::SOFT_REF_ADDR, 32'h0202);
      overTemp <= 1'h1;
      repeat (20) @(posedge clk);
      rd("ref hot", dps_pkg::SOFT_REF_ADDR, 32'h0);
      post("pok hot", 32'h3, {chanTwoPowerOkOe, chanOnePowerOkOe});
      // Board sequencing: channel two's enable waits for channel one's power-ok
      bus(dps_pkg::OSC_PERIOD_ADDR, 1'h1, 32'h4);
      chanTwoEnable <= 1'h0;
      overTemp <= 1'h0;
      n = 0;
      while (chanOnePowerOkOe !== 1'h0 && n < 10000) begin
         @(posedge clk);
         n++;
      end
      post("pok seq", 32'h2, {chanTwoPowerOkOe, chanOnePowerOkOe});
      chanTwoEnable <= 1'h1;
      repeat (600) @(posedge clk);
      rd("ref seq", dps_pkg::SOFT_REF_ADDR, 32'h0440);
      $display("protection done");
      finish_test();
   end
endmodule // tb_dps_sequencer
`default_nettype wire
